//--- bench/ddrc_host_bench.sv
// ddrc_host_bench: self-checking bench for the memory command controller.
// assumes: memory model on the pins; the checker binds itself.
`timescale 1ns/1ps
`include "ddrc_cfg.svh"
module ddrc_host_bench import ddrc_pkg::*; ;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  ddrc_req_t req = '0;
  logic req_valid = 1'b0;
  logic req_ready, rd_valid, in_self_refresh, mem_ck, dq_oe, dqs_o, dqs_oe;
  logic mem_ck_n, dm;
  logic [15:0] rd_data;
  ddrc_pins_t mem_cmd;
  logic [7:0] dq_o, model_dq;
  int mismatches = 0;
  int compares = 0;
  ddrc_op_t prev_op = DDRC_OP_NOP;
  logic [15:0] exp_q [$];
  // shared lines: the driver wins, otherwise the far side or a toggle
  wire [7:0] dq_in = dq_oe ? dq_o : model_dq;
  wire dqs_in = dqs_oe ? dqs_o : mem_ck;
  ddrc_host dut (.clk(clk), .nrst(nrst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .in_self_refresh(in_self_refresh), .mem_ck(mem_ck), .mem_ck_n(mem_ck_n),
    .mem_cmd(mem_cmd), .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq_in),
    .mem_dqs_o(dqs_o), .mem_dqs_oe(dqs_oe), .mem_dqs_i(dqs_in), .mem_dm(dm));
  ddrc_mem_model mem (.mem_ck(mem_ck), .mem_cmd(mem_cmd), .mem_dq_o(dq_o),
    .mem_dqs_o(dqs_o), .mem_dqs_oe(dqs_oe), .mem_dq_i(model_dq));
  // ==========================================================
  // clock, checking and closing
  initial forever #50 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // minimums in memory clocks of 200 ns, rounded up, as clk ticks
  function automatic logic [31:0] ck2(input int ns);
    return 2 * ((ns + 199) / 200);
  endfunction
  function automatic logic [31:0] exp_gap(input ddrc_op_t p, input ddrc_op_t n);
    logic rd;
    rd = (n == DDRC_OP_READ || n == DDRC_OP_READ_AP);
    if (p == DDRC_OP_REFRESH) return ck2(80);
    if (p == DDRC_OP_MODE_LOAD) return ck2(16);
    if (p == DDRC_OP_ACT && n == DDRC_OP_ACT) return ck2(15);
    if (p == DDRC_OP_ACT && n == DDRC_OP_READ_AP) return ck2(20);
    if (p == DDRC_OP_WRITE && rd) return 32'h6; // data clocks plus one
    if (p == DDRC_OP_SR_EXIT) return rd ? 32'h190 : ck2(80);
    return 32'h2;
  endfunction
  // waits at the falling edge for ready, then lets the taking edge pass
  task automatic issue(input ddrc_op_t op, input logic [1:0] b,
      input logic [3:0] c, input logic [15:0] d, output logic [31:0] g,
      output logic [31:0] e);
    int n;
    @(negedge clk);
    req = '{op, b, {9'h000, c}, d};
    req_valid = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    g = n + 1;
    e = exp_gap(prev_op, op);
    prev_op = op;
  endtask
  // read bursts compared in order of issue
  always @(negedge clk) begin
    if (rd_valid === 1'b1 && exp_q.size() == 0) begin
      check({16'h0, rd_data}, 32'hFFFFFFFF);
    end else if (rd_valid === 1'b1) begin
      check({16'h0, rd_data}, {16'h0, exp_q.pop_front()});
    end
  end
  initial begin
    #(6000 * 100);
    mismatches++;
    finish_test();
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [31:0] g, e;
    logic [1:0] b;
    logic [3:0] c;
    logic [15:0] d;
    int n;
    repeat (3) @(negedge clk);
    check({28'h0, dqs_oe, dq_oe, req_ready, mem_cmd.cs_n}, 32'h1);
    nrst = 1'b1;
    void'($urandom(84));
    issue(DDRC_OP_ACT, 2'h0, 4'h0, 16'h0, g, e);
    issue(DDRC_OP_ACT, 2'h1, 4'h0, 16'h0, g, e);
    check(g, e);
    issue(DDRC_OP_WRITE, 2'h1, 4'h3, 16'hA55A, g, e);
    check(g, e);
    issue(DDRC_OP_WRITE, 2'h1, 4'hF, 16'h0FF0, g, e);
    check(g, e);
    issue(DDRC_OP_READ, 2'h1, 4'h3, 16'h0, g, e);
    check(g, e);
    issue(DDRC_OP_READ, 2'h1, 4'hF, 16'h0, g, e);
    check(g, e);
    exp_q.push_back(16'hA55A);
    exp_q.push_back(16'h0FF0);
    // explicit close goes at the next slot: no counter guards it
    issue(DDRC_OP_PRE, 2'h1, 4'h0, 16'h0, g, e);
    check(g, e);
    issue(DDRC_OP_MODE_LOAD, 2'h0, 4'h2, 16'h0, g, e);
    issue(DDRC_OP_ACT, 2'h2, 4'h0, 16'h0, g, e);
    check(g, e);
    for (int i = 0; i < 8; i++) begin
      issue(DDRC_OP_REFRESH, 2'h0, 4'h0, 16'h0, g, e);
      if (i > 0) check(g, e);
    end
    n = 0;
    repeat (20) begin
      @(negedge clk);
      if (req_ready !== 1'b0) n++;
    end
    check(n, 0);
    issue(DDRC_OP_ACT, 2'h1, 4'h0, 16'h0, g, e);
    issue(DDRC_OP_READ_AP, 2'h1, 4'h3, 16'h0, g, e);
    check(g, e);
    // the autoclose bit is forced on the pins whatever the address says
    @(negedge clk);
    check(mem_cmd.a[`DDRC_AP_BIT], 1'b1);
    exp_q.push_back(16'hA55A);
    for (int k = 0; k < 2; k++) begin
      issue(DDRC_OP_SR_ENTER, 2'h0, 4'h0, 16'h0, g, e);
      repeat (2) @(negedge clk);
      check(in_self_refresh, 1);
      check({30'h0, dm, mem_ck ^ mem_ck_n}, 32'h1);
      issue(DDRC_OP_SR_EXIT, 2'h0, 4'h0, 16'h0, g, e);
      if (k == 0) issue(DDRC_OP_ACT, 2'h1, 4'h0, 16'h0, g, e);
      else issue(DDRC_OP_READ, 2'h1, 4'h3, 16'h0, g, e);
      check(g, e);
    end
    exp_q.push_back(16'hA55A);
    for (int i = 0; i < 8; i++) begin
      b = 2'($urandom);
      c = 4'($urandom);
      d = 16'($urandom);
      issue(DDRC_OP_ACT, b, 4'h0, 16'h0, g, e);
      issue(DDRC_OP_WRITE, b, c, d, g, e);
      check(g, e);
      issue(DDRC_OP_READ_AP, b, c, 16'h0, g, e);
      check(g, e);
      exp_q.push_back(d);
    end
    @(negedge clk);
    req_valid = 1'b0;
    repeat (20) @(negedge clk);
    check(exp_q.size(), 0);
    finish_test();
  end
endmodule

//--- bench/ddrc_host_properties.sv
// ddrc_host_properties: timing checks on the controller's pins.
// assumes: bound to ddrc_host; a single clock domain on clk.
`timescale 1ns/1ps
`include "ddrc_cfg.svh"
module ddrc_host_properties import ddrc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire ddrc_req_t req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic in_self_refresh,
  input wire logic mem_ck,
  input wire logic mem_ck_n,
  input wire ddrc_pins_t mem_cmd,
  input wire logic [7:0] mem_dq_o,
  input wire logic mem_dq_oe,
  input wire logic [7:0] mem_dq_i,
  input wire logic mem_dqs_o,
  input wire logic mem_dqs_oe,
  input wire logic mem_dqs_i,
  input wire logic mem_dm
);
  // ==========================================================
  // helper decode and counters
  wire take = req_valid && req_ready;
  wire wr_take = take && req.op == DDRC_OP_WRITE;
  wire rd_op = req.op == DDRC_OP_READ || req.op == DDRC_OP_READ_AP;
  wire rd_take = take && rd_op;
  wire [3:0] code = {mem_cmd.cs_n, mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n};
  logic [3:0] ref_run_reg;
  logic [8:0] srx_age_reg;
  // age saturates so a stale exit never wraps back into the read window
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_run_reg <= 4'h0;
      srx_age_reg <= 9'h000;
    end else begin
      if (take && req.op == DDRC_OP_REFRESH) ref_run_reg <= ref_run_reg + 4'h1;
      else if (take && req.op != DDRC_OP_NOP) ref_run_reg <= 4'h0;
      if (take && req.op == DDRC_OP_SR_EXIT) srx_age_reg <= 9'h001;
      else if (srx_age_reg != 9'h000 && srx_age_reg != 9'h1FF)
        srx_age_reg <= srx_age_reg + 9'h001;
    end
  end
  // ==========================================================
  // write strobe steps and assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_preamble;
    ##2 (mem_dqs_oe && !mem_dqs_o);
  endsequence
  sequence s_first_beat;
    ##2 (mem_dqs_o && mem_dq_oe);
  endsequence
  a_refresh_gap: assert property (take && req.op == DDRC_OP_REFRESH |=>
    code == `DDRC_ENC_REF && !take) else $error("refresh gap broken");
  a_act_spacing: assert property (take && req.op == DDRC_OP_ACT |=>
    code == `DDRC_ENC_ACT && !take) else $error("activate gap broken");
  a_write_read_turn: assert property (wr_take |=> (!rd_take)[*5])
    else $error("read too soon after write");
  a_column_hold: assert property (wr_take || rd_take |=> ##1
    $stable(mem_cmd)) else $error("column command not held");
  a_mode_gap: assert property (take && req.op == DDRC_OP_MODE_LOAD |=>
    code == `DDRC_ENC_MRS && !take) else $error("mode gap broken");
  a_srx_nonread: assert property (take && req.op == DDRC_OP_SR_EXIT |=>
    mem_cmd.cke && !take) else $error("exit gap broken");
  a_srx_read_gap: assert property (rd_take && srx_age_reg != 9'h000 |->
    srx_age_reg >= 9'h190) else $error("read too soon after exit");
  a_refresh_burst: assert property (take
    && req.op == DDRC_OP_REFRESH |-> ref_run_reg < 4'h8)
    else $error("refresh burst too long");
  a_write_preamble: assert property (wr_take && !mem_dqs_oe |->
    s_preamble ##0 s_first_beat) else $error("write preamble wrong");
  a_strobe_tail: assert property ($fell(mem_dqs_oe) |->
    !$past(mem_dqs_o) && $past(mem_dqs_o, 2)) else $error("strobe tail wrong");
  a_strobe_fall: assert property ($fell(mem_dqs_o)
    && $past(mem_dqs_oe) |-> $fell(mem_ck))
    else $error("strobe fall off clock edge");
  a_strobe_high: assert property ($rose(mem_dqs_o) && mem_dqs_oe |=>
    !mem_dqs_o) else $error("strobe high phase wrong");
endmodule

bind ddrc_host ddrc_host_properties chk (.clk(clk), .nrst(nrst), .req(req),
  .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data),
  .rd_valid(rd_valid), .in_self_refresh(in_self_refresh), .mem_ck(mem_ck),
  .mem_ck_n(mem_ck_n), .mem_cmd(mem_cmd), .mem_dq_o(mem_dq_o),
  .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i), .mem_dqs_o(mem_dqs_o),
  .mem_dqs_oe(mem_dqs_oe), .mem_dqs_i(mem_dqs_i), .mem_dm(mem_dm));

//--- bench/ddrc_mem_model.sv
// ddrc_mem_model: behavioural memory on the far side of the controller.
// assumes: bursts of two bytes, read latency of two memory clocks.
`timescale 1ns/1ps
`include "ddrc_cfg.svh"
module ddrc_mem_model import ddrc_pkg::*; (
  input wire logic mem_ck,
  input wire ddrc_pins_t mem_cmd,
  input wire logic [7:0] mem_dq_o,
  input wire logic mem_dqs_o,
  input wire logic mem_dqs_oe,
  output logic [7:0] mem_dq_i
);
  // ==========================================================
  // storage and decode
  logic [15:0] store [64];
  logic [5:0] wq [$];
  logic [1:0] rd_pipe = 2'h0;
  logic [5:0] ra0, ra1, hi_addr;
  logic [7:0] w0;
  logic hi_word = 1'b0;
  logic got0 = 1'b0;
  wire [3:0] code = {mem_cmd.cs_n, mem_cmd.ras_n, mem_cmd.cas_n, mem_cmd.we_n};
  wire [5:0] slot = {mem_cmd.ba, mem_cmd.a[3:0]};
  initial mem_dq_i = 8'h00;
  // a column command is taken at every rise, the second read beat goes
  // out on the fall; one process keeps the data lines single-driven
  always @(posedge mem_ck or negedge mem_ck) begin
    if (mem_ck) begin
      if (code == `DDRC_ENC_WR) wq.push_back(slot);
      if (rd_pipe[1]) mem_dq_i <= store[ra1][7:0];
      else mem_dq_i <= ~mem_dq_i;
      hi_word <= rd_pipe[1];
      hi_addr <= ra1;
      rd_pipe <= {rd_pipe[0], code == `DDRC_ENC_RD};
      ra1 <= ra0;
      ra0 <= slot;
    end else if (hi_word) begin
      mem_dq_i <= store[hi_addr][15:8];
    end else begin
      mem_dq_i <= ~mem_dq_i;
    end
  end
  // beats latched just after each strobe edge; any tail length is fine
  always @(mem_dqs_o) begin
    #1;
    if (mem_dqs_o) begin
      w0 = mem_dq_o;
      got0 = mem_dqs_oe;
    end else begin
      if (got0 && wq.size() != 0) begin
        store[wq.pop_front()] = {mem_dq_o, w0};
      end
      got0 = 1'b0;
    end
  end
endmodule

//--- verilog/ddrc_cfg.svh
// ddrc_cfg.svh: timing counts, timer slots and pin encodings for the
// double-data-rate memory command controller.
// assumes: included by bare name; every figure is the slowest grade.
`ifndef DDRC_CFG_SVH
`define DDRC_CFG_SVH

// ==========================================================
// clocks
`define DDRC_CLK_NS 100
// the memory clock is clk divided by two
`define DDRC_TCK_NS (2 * `DDRC_CLK_NS)
// least times round up to whole memory clocks, never below one
`define DDRC_NS2CK(ns) (((ns) + `DDRC_TCK_NS - 1) / `DDRC_TCK_NS)
// a wait of n memory clocks in clk ticks as a timer load value
`define DDRC_TICKS(ck) (2 * (ck) - 1)

// ==========================================================
// command gaps, as printed
`define DDRC_RFC_NS 80
`define DDRC_RRD_NS 15
`define DDRC_MRD_NS 16
`define DDRC_XSNR_NS 80
`define DDRC_RCD_NS 20
`define DDRC_RAP_NS 20
`define DDRC_WTR_CK 1
`define DDRC_CCD_CK 1
`define DDRC_XSRD_CK 200
`define DDRC_REF_BURST_MAX 4'h8
// read latency in memory clocks; the half-cycle setting is not used
`define DDRC_CL 2
// write command to last data: preamble clock plus one data clock
`define DDRC_WR_DATA_CK 2

// ==========================================================
// gap timer slots
`define DDRC_T_RFC 0
`define DDRC_T_RRD 1
`define DDRC_T_WTR 2
`define DDRC_T_MRD 3
`define DDRC_T_XSNR 4
`define DDRC_T_XSRD 5
`define DDRC_T_RCD 6
`define DDRC_T_RAP 7
`define DDRC_NTIMERS 8
`define DDRC_TW 9

// ==========================================================
// read capture tap in clk ticks after the issuing edge
`define DDRC_RD_TAP (2 * `DDRC_CL + 3)

// ==========================================================
// command encodings {select_n, row_n, col_n, write_n}
`define DDRC_ENC_NOP 4'h7
`define DDRC_ENC_ACT 4'h3
`define DDRC_ENC_RD 4'h5
`define DDRC_ENC_WR 4'h4
`define DDRC_ENC_PRE 4'h2
`define DDRC_ENC_REF 4'h1
`define DDRC_ENC_MRS 4'h0
`define DDRC_AP_BIT 10

`endif

//--- verilog/ddrc_gap_timers.sv
// ddrc_gap_timers: a bank of down-counters, one per command gap.
// assumes: loads are one-cycle pulses from the same clock domain.
`timescale 1ns/1ps
`include "ddrc_cfg.svh"
module ddrc_gap_timers import ddrc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [`DDRC_NTIMERS-1:0] load,
  input wire logic [`DDRC_NTIMERS-1:0][`DDRC_TW-1:0] load_val,
  output logic [`DDRC_NTIMERS-1:0] done
);

  logic [`DDRC_NTIMERS-1:0][`DDRC_TW-1:0] cnt_reg;

  // ==========================================================
  // counters
  for (genvar i = 0; i < `DDRC_NTIMERS; i++) begin : g_t
    // zero means the dependent command may go
    assign done[i] = (cnt_reg[i] == '0);
    // loaded on the constraining command, then count down to zero
    always_ff @(posedge clk) begin
      if (!nrst) begin
        cnt_reg[i] <= '0;
      end else if (load[i]) begin
        cnt_reg[i] <= load_val[i];
      end else if (!done[i]) begin
        cnt_reg[i] <= cnt_reg[i] - 1'b1;
      end
    end
  end

endmodule

//--- verilog/ddrc_host.sv
// ddrc_host: controller that drives a double-data-rate memory over its
// command, clock, data and strobe pins, spacing commands by the gaps.
// assumes: one requester on clk; the memory clock is made here as clk/2;
// the memory answers reads at the fixed read latency.
`timescale 1ns/1ps
`include "ddrc_cfg.svh"
module ddrc_host import ddrc_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire ddrc_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic in_self_refresh,
  output logic mem_ck,
  output logic mem_ck_n,
  output ddrc_pins_t mem_cmd,
  output logic [7:0] mem_dq_o,
  output logic mem_dq_oe,
  input wire logic [7:0] mem_dq_i,
  output logic mem_dqs_o,
  output logic mem_dqs_oe,
  input wire logic mem_dqs_i,
  output logic mem_dm
);

  // ==========================================================
  // timer load values, in clk ticks
  localparam logic [`DDRC_TW-1:0] LV_RFC =
    `DDRC_TW'(`DDRC_TICKS(`DDRC_NS2CK(`DDRC_RFC_NS)));
  localparam logic [`DDRC_TW-1:0] LV_RRD =
    `DDRC_TW'(`DDRC_TICKS(`DDRC_NS2CK(`DDRC_RRD_NS)));
  localparam logic [`DDRC_TW-1:0] LV_WTR =
    `DDRC_TW'(`DDRC_TICKS(`DDRC_WTR_CK + `DDRC_WR_DATA_CK));
  localparam logic [`DDRC_TW-1:0] LV_MRD =
    `DDRC_TW'(`DDRC_TICKS(`DDRC_NS2CK(`DDRC_MRD_NS)));
  localparam logic [`DDRC_TW-1:0] LV_XSNR =
    `DDRC_TW'(`DDRC_TICKS(`DDRC_NS2CK(`DDRC_XSNR_NS)));
  localparam logic [`DDRC_TW-1:0] LV_XSRD =
    `DDRC_TW'(`DDRC_TICKS(`DDRC_XSRD_CK));
  localparam logic [`DDRC_TW-1:0] LV_RCD =
    `DDRC_TW'(`DDRC_TICKS(`DDRC_NS2CK(`DDRC_RCD_NS)));
  localparam logic [`DDRC_TW-1:0] LV_RAP =
    `DDRC_TW'(`DDRC_TICKS(`DDRC_NS2CK(`DDRC_RAP_NS)));

  // ==========================================================
  // command pin encoding
  function automatic ddrc_pins_t encode(input ddrc_req_t r,
                                        input logic cke);
    ddrc_pins_t p;
    logic [3:0] e;
    e = `DDRC_ENC_NOP;
    case (r.op)
      DDRC_OP_ACT: e = `DDRC_ENC_ACT;
      DDRC_OP_READ: e = `DDRC_ENC_RD;
      DDRC_OP_READ_AP: e = `DDRC_ENC_RD;
      DDRC_OP_WRITE: e = `DDRC_ENC_WR;
      DDRC_OP_PRE: e = `DDRC_ENC_PRE;
      DDRC_OP_REFRESH: e = `DDRC_ENC_REF;
      DDRC_OP_SR_ENTER: e = `DDRC_ENC_REF;
      DDRC_OP_MODE_LOAD: e = `DDRC_ENC_MRS;
      default: e = `DDRC_ENC_NOP;
    endcase
    p.cke = cke;
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = e;
    p.ba = r.bank;
    p.a = r.addr;
    if (r.op == DDRC_OP_READ) begin
      p.a[`DDRC_AP_BIT] = 1'b0;
    end
    if (r.op == DDRC_OP_READ_AP) begin
      p.a[`DDRC_AP_BIT] = 1'b1;
    end
    return p;
  endfunction

  // ==========================================================
  // state
  logic ck_reg;
  logic ckn_reg;
  logic in_sr_reg;
  logic cke_reg;
  logic [3:0] ref_run_reg;
  ddrc_pins_t cmd_reg;
  logic [4:0] wr_sh_reg;
  logic [15:0] wd_reg;
  logic [15:0] wd_hold_reg;
  logic [7:0] dq_o_reg;
  logic dq_oe_reg;
  logic dqs_o_reg;
  logic dqs_oe_reg;
  logic [`DDRC_RD_TAP+1:0] rd_sh_reg;
  logic [7:0] dq_s1_reg;
  logic [7:0] dq_s2_reg;
  logic [7:0] rd_lo_reg;
  logic [15:0] rd_data_reg;
  logic rd_valid_reg;

  // ==========================================================
  // decode of the request and the gap timers
  logic [`DDRC_NTIMERS-1:0] t_done;
  logic [`DDRC_NTIMERS-1:0] t_load;
  logic [`DDRC_NTIMERS-1:0][`DDRC_TW-1:0] t_val;
  wire slot = ck_reg;
  wire is_act = (req.op == DDRC_OP_ACT);
  wire is_rd = (req.op == DDRC_OP_READ);
  wire is_rdap = (req.op == DDRC_OP_READ_AP);
  wire is_wr = (req.op == DDRC_OP_WRITE);
  wire is_ref = (req.op == DDRC_OP_REFRESH);
  wire is_mrs = (req.op == DDRC_OP_MODE_LOAD);
  wire is_sre = (req.op == DDRC_OP_SR_ENTER);
  wire is_srx = (req.op == DDRC_OP_SR_EXIT);
  wire is_nop = (req.op == DDRC_OP_NOP);
  wire is_any_rd = is_rd | is_rdap;

  // nothing may follow a refresh or mode load until their gaps pass
  wire base_ok = !in_sr_reg & t_done[`DDRC_T_RFC]
    & t_done[`DDRC_T_MRD];
  wire nonrd_ok = base_ok & t_done[`DDRC_T_XSNR];
  wire ref_ok = nonrd_ok
    & (ref_run_reg < `DDRC_REF_BURST_MAX);
  wire act_ok = nonrd_ok & t_done[`DDRC_T_RRD];
  // reads wait only on the long relock gap, not on the non-read gap
  wire rd_ok = base_ok & t_done[`DDRC_T_XSRD]
    & t_done[`DDRC_T_WTR]
    & t_done[`DDRC_T_RCD];
  wire rdap_ok = rd_ok & t_done[`DDRC_T_RAP];
  wire wr_ok = nonrd_ok & t_done[`DDRC_T_RCD];
  wire srx_ok = in_sr_reg;

  // no column counter: back-to-back column commands go every slot, except a read after a write, which waits on the turn gap
  wire op_ok = is_nop | (is_act & act_ok) | (is_rd & rd_ok)
    | (is_rdap & rdap_ok) | (is_wr & wr_ok)
    | ((is_ref | is_sre) & ref_ok)
    | ((is_mrs | req.op == DDRC_OP_PRE) & nonrd_ok)
    | (is_srx & srx_ok);

  // requests are taken only on the edge where the memory clock falls
  assign req_ready = slot & op_ok;
  wire issue = req_valid & req_ready;

  // ==========================================================
  // timer loads
  assign t_load[`DDRC_T_RFC] = issue & is_ref;
  assign t_load[`DDRC_T_RRD] = issue & is_act;
  assign t_load[`DDRC_T_WTR] = issue & is_wr;
  assign t_load[`DDRC_T_MRD] = issue & is_mrs;
  assign t_load[`DDRC_T_XSNR] = issue & is_srx;
  assign t_load[`DDRC_T_XSRD] = issue & is_srx;
  assign t_load[`DDRC_T_RCD] = issue & is_act;
  assign t_load[`DDRC_T_RAP] = issue & is_act;
  assign t_val[`DDRC_T_RFC] = LV_RFC;
  assign t_val[`DDRC_T_RRD] = LV_RRD;
  assign t_val[`DDRC_T_WTR] = LV_WTR;
  assign t_val[`DDRC_T_MRD] = LV_MRD;
  assign t_val[`DDRC_T_XSNR] = LV_XSNR;
  assign t_val[`DDRC_T_XSRD] = LV_XSRD;
  assign t_val[`DDRC_T_RCD] = LV_RCD;
  assign t_val[`DDRC_T_RAP] = LV_RAP;

  ddrc_gap_timers u_timers (
    .clk(clk),
    .nrst(nrst),
    .load(t_load),
    .load_val(t_val),
    .done(t_done)
  );

  // ==========================================================
  // memory clock divider
  // the 2:1 divider fixes the memory period at twice clk; the period
  // limits tied to the half-cycle latency are therefore not reachable
  // and the controller stays on the whole-cycle setting
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ck_reg <= 1'b0;
      ckn_reg <= 1'b1;
    end else begin
      ck_reg <= ~ck_reg;
      ckn_reg <= ck_reg;
    end
  end

  // ==========================================================
  // self-refresh and refresh burst tracking
  wire cke_next = (issue & is_sre) ? 1'b0 :
                  (issue & is_srx) ? 1'b1 : cke_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_sr_reg <= 1'b0;
      cke_reg <= 1'b1;
    end else begin
      in_sr_reg <= ~cke_next;
      cke_reg <= cke_next;
    end
  end

  // any real command between refreshes ends the burst, except a self-refresh entry, which counts as a refresh
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ref_run_reg <= 4'h0;
    end else if (issue & (is_ref | is_sre)) begin
      ref_run_reg <= ref_run_reg + 4'h1;
    end else if (issue & !is_nop) begin
      ref_run_reg <= 4'h0;
    end
  end

  // ==========================================================
  // command pins, changed only as the memory clock falls so they are
  // stable around its rising edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_reg <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                   we_n: 1'b1, ba: 2'h0, a: 13'h0000};
    end else if (slot) begin
      cmd_reg <= issue ? encode(req, cke_next)
                       : encode('0, cke_reg);
    end
  end

  // ==========================================================
  // write data and strobe
  // tick k after the issuing edge E: strobe driven low from E+1 (valid
  // by the memory clock edge that opens the preamble), high E+3, low
  // E+4, tail low to E+5 then released; data words at E+3 and E+4
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_sh_reg <= 5'h00;
      wd_reg <= 16'h0000;
      wd_hold_reg <= 16'h0000;
    end else begin
      wr_sh_reg <= {wr_sh_reg[3:0], issue & is_wr};
      if (issue & is_wr) begin
        wd_reg <= req.wdata;
      end
      // copied early: the next write may overwrite wd_reg at E+2
      if (wr_sh_reg[1]) begin
        wd_hold_reg <= wd_reg;
      end
    end
  end

  // strobe edges coincide with memory clock edges, so every fall is
  // half a clock from each rise; the preamble is one clock long and every other phase half a clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dqs_o_reg <= 1'b0;
      dqs_oe_reg <= 1'b0;
      dq_o_reg <= 8'h00;
      dq_oe_reg <= 1'b0;
    end else begin
      dqs_oe_reg <= |wr_sh_reg[3:0];
      dqs_o_reg <= wr_sh_reg[2];
      dq_oe_reg <= wr_sh_reg[2] | wr_sh_reg[3];
      if (wr_sh_reg[2]) begin
        dq_o_reg <= wd_hold_reg[7:0];
      end else if (wr_sh_reg[3]) begin
        dq_o_reg <= wd_hold_reg[15:8];
      end
    end
  end

  // a back-to-back write finds the strobe still low from the last
  // fall and keeps it driven; a half-clock tail is inside the window
  // and a longer one would only delay the next bus turnaround
  assign mem_dqs_oe = dqs_oe_reg;
  assign mem_dqs_o = dqs_o_reg;
  assign mem_dq_oe = dq_oe_reg;
  assign mem_dq_o = dq_o_reg;
  assign mem_dm = 1'b0;

  // ==========================================================
  // read capture through a two-stage synchroniser
  // fixed latency: no strobe-based capture, so the far end must hold
  // each word for a full half clock from its memory clock edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
      rd_sh_reg <= '0;
    end else begin
      dq_s1_reg <= mem_dq_i;
      dq_s2_reg <= dq_s1_reg;
      rd_sh_reg <= {rd_sh_reg[`DDRC_RD_TAP:0], issue & is_any_rd};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_lo_reg <= 8'h00;
      rd_data_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_sh_reg[`DDRC_RD_TAP+1];
      if (rd_sh_reg[`DDRC_RD_TAP]) begin
        rd_lo_reg <= dq_s2_reg;
      end
      if (rd_sh_reg[`DDRC_RD_TAP+1]) begin
        rd_data_reg <= {dq_s2_reg, rd_lo_reg};
      end
    end
  end

  // ==========================================================
  // outputs
  assign mem_ck = ck_reg;
  assign mem_ck_n = ckn_reg;
  assign mem_cmd = cmd_reg;
  assign in_self_refresh = in_sr_reg;
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;

endmodule

//--- verilog/ddrc_pkg.sv
// ddrc_pkg: request, command and pin bundle types of the controller.
// assumes: nothing beyond the tool's SystemVerilog support.
package ddrc_pkg;

  // ==========================================================
  // user requests
  typedef enum logic [3:0] {
    DDRC_OP_NOP,
    DDRC_OP_ACT,
    DDRC_OP_READ,
    DDRC_OP_READ_AP,
    DDRC_OP_WRITE,
    DDRC_OP_PRE,
    DDRC_OP_REFRESH,
    DDRC_OP_MODE_LOAD,
    DDRC_OP_SR_ENTER,
    DDRC_OP_SR_EXIT
  } ddrc_op_t;

  typedef struct packed {
    ddrc_op_t op;
    logic [1:0] bank;
    logic [12:0] addr;
    logic [15:0] wdata;
  } ddrc_req_t;

  // ==========================================================
  // command pins toward the memory
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] a;
  } ddrc_pins_t;

endpackage
